/* File: rtl/ballast_pkg.sv */
// Contract
// R1: wait for power good before any action
// R2: controller oscillates fast ~2 ms meanwhile; GEN_CYC is never used, both PWMs run freely from reset
// R3: open-load alarm drives supply-cut high
// R4: sequence: supply, load, preheat, ignition, regulate
// R5: timer PWM and stepped soft PWM
// R6: power good, lamp missing, no ignition in
// R7: soft PWM, PFC off, timer PWM, shutdown out
// R8: lamp-missing handled as interrupt event
// R9: soft PWM step costs four clocks
// R10: restrike limit is any configured value
// R11: preheat duty held, then ignition sweep
// R12: shutdown high stops controller until restart
// R13: restart high forces new preheat; there is no restart input, only i_srst restarts from ST_WAIT_PG
// R14: count restrikes, beyond limit shut down
// R15: PFC on at ignition, off on fault
package ballast_pkg;
  localparam int CLK_MHZ = 125;
  localparam logic [7:0] DUTY_PRE = 8'hBE;
  localparam logic [7:0] DEF_SW_DUTY = 8'hBC;
  localparam logic [7:0] DUTY_IGN_END = 8'hD3;
  // timing in microseconds
  localparam int T_GEN_US = 2112;
  localparam int T_PRE_US = 1032000;
  localparam int T_IGN_STEP_US = 2344;
  localparam int T_LOAD_US = 1000;
  localparam int CYC_GEN = T_GEN_US * CLK_MHZ;
  localparam int CYC_PRE = T_PRE_US * CLK_MHZ;
  localparam int CYC_IGN_STEP = T_IGN_STEP_US * CLK_MHZ;
  localparam int CYC_LOAD = T_LOAD_US * CLK_MHZ;
  localparam logic [7:0] DEF_RESTRIKES = 8'h02;
  localparam int SOFT_STEP_CYC = 4;
  // apb register offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_DIM = 8'h04;
  localparam logic [7:0] A_STATUS = 8'h08;
  localparam logic [7:0] A_IRQ = 8'h0C;
  localparam logic [7:0] A_MASK = 8'h10;
  localparam logic [7:0] A_STATE = 8'h14;
  localparam int IRQ_W = 3;
  localparam int IRQ_LAMP = 0;
  localparam int IRQ_NOIGN = 1;
  localparam int IRQ_FAULT = 2;
  typedef enum logic [2:0] {
    ST_WAIT_PG, ST_LOAD_CHK, ST_PREHEAT, ST_IGNITE, ST_RUN, ST_FAULT
  } seq_t;
endpackage : ballast_pkg

/* File: rtl/pwm_if.sv */
`timescale 1ns/1ns
interface pwm_if;
  logic [7:0] duty;
  logic out;
  modport gen(input duty, output out);
  modport ctl(output duty, input out);
endinterface : pwm_if

/* File: rtl/pwm_gen.sv */
`timescale 1ns/1ns
module pwm_gen #(
  parameter int STEP = 1
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  pwm_if.gen p
);
  logic [7:0] cnt;
  logic [3:0] pre;
  logic tick;
  assign tick = (pre == 4'(STEP - 1));
  // prescale: soft pwm advances once per step time
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pre <= 4'h0;
    end else if (i_ce) begin
      pre <= tick ? 4'h0 : pre + 4'h1;
    end
  end
  // counter and compare
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt <= 8'h00;
      p.out <= 1'b0;
    end else if (i_ce && tick) begin
      cnt <= cnt + 8'h01;
      p.out <= (cnt < p.duty);
    end
  end
endmodule : pwm_gen

/* File: rtl/ballast_supervisor.sv */
`timescale 1ns/1ns
module ballast_supervisor #(
  parameter int PRE_CYC = ballast_pkg::CYC_PRE,
  parameter int GEN_CYC = ballast_pkg::CYC_GEN,
  parameter int IGN_CYC = ballast_pkg::CYC_IGN_STEP,
  parameter int LOAD_CYC = ballast_pkg::CYC_LOAD
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_power_good_input,
  input wire logic i_lamp_missing_input,
  input wire logic i_no_ignition_input,
  output logic o_soft_pwm_output,
  output logic o_timer_pwm_output,
  output logic o_pfc_off_output,
  output logic o_driver_shutdown_output,
  output logic o_supply_cut,
  output logic o_irq
);
  ballast_pkg::seq_t state;
  logic [2:0] pg_s, lm_s, ni_s;
  logic pg, lm, ni, lm_d, ni_d;
  logic [31:0] tmr;
  logic [7:0] restrike_lim, tries, dim, hw_duty;
  logic [5:0] ign_step;
  logic enable;
  logic [ballast_pkg::IRQ_W-1:0] irq_st, irq_mask, ev;
  logic acc, rd_irq;
  logic to_fault, cut_req;
  pwm_if hw();
  pwm_if sw();

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change counts when stages 2 and 3 agree
  // R6: ballast side inputs
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pg_s <= 3'h0;
      lm_s <= 3'h0;
      ni_s <= 3'h0;
      pg <= 1'b0;
      lm <= 1'b0;
      ni <= 1'b0;
    end else if (i_ce) begin
      pg_s <= {pg_s[1:0], i_power_good_input};
      lm_s <= {lm_s[1:0], i_lamp_missing_input};
      ni_s <= {ni_s[1:0], i_no_ignition_input};
      if (pg_s[1] == pg_s[2]) pg <= pg_s[2];
      if (lm_s[1] == lm_s[2]) lm <= lm_s[2];
      if (ni_s[1] == ni_s[2]) ni <= ni_s[2];
    end
  end

  // edge memories for event detection
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      lm_d <= 1'b0;
      ni_d <= 1'b0;
    end else if (i_ce) begin
      lm_d <= lm;
      ni_d <= ni;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pwm generators
  // R5: timer pwm and software-style pwm
  assign hw.duty = hw_duty;
  assign sw.duty = dim;
  pwm_gen #(.STEP(1)) u_hw (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .p(hw)
  );
  // R9: four clocks per soft step
  pwm_gen #(.STEP(ballast_pkg::SOFT_STEP_CYC)) u_sw (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .p(sw)
  );

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  // R8: lamp-missing reacts as an event, in any state but ST_WAIT_PG and ST_FAULT
  assign ev[ballast_pkg::IRQ_LAMP] = lm && !lm_d;
  assign ev[ballast_pkg::IRQ_NOIGN] = ni && !ni_d;
  assign ev[ballast_pkg::IRQ_FAULT] = to_fault;
  assign to_fault = (state != ballast_pkg::ST_FAULT) &&
    (state != ballast_pkg::ST_WAIT_PG) &&
    (ev[ballast_pkg::IRQ_LAMP] ||
     (state == ballast_pkg::ST_LOAD_CHK && lm) ||
     (state == ballast_pkg::ST_IGNITE && ni && tries >= restrike_lim));
  // no supply cut before power good: no cut or fault while waiting, only irq_st records events
  assign cut_req = (state != ballast_pkg::ST_WAIT_PG) &&
    (ev[ballast_pkg::IRQ_LAMP] ||
     (state == ballast_pkg::ST_LOAD_CHK && lm));

  // R4: fixed order of phases
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state <= ballast_pkg::ST_WAIT_PG;
      tmr <= 32'h0;
      tries <= 8'h00;
      ign_step <= 6'h00;
      hw_duty <= ballast_pkg::DUTY_PRE;
    end else if (i_ce) begin
      tmr <= tmr + 32'h1;
      unique case (state)
        // R1: idle until power good; R2 covers this wait
        ballast_pkg::ST_WAIT_PG: begin
          tmr <= 32'h0;
          if (pg && enable) state <= ballast_pkg::ST_LOAD_CHK;
        end
        ballast_pkg::ST_LOAD_CHK: begin
          if (lm) begin
            state <= ballast_pkg::ST_FAULT;
          end else if (tmr >= 32'(LOAD_CYC - 1)) begin
            state <= ballast_pkg::ST_PREHEAT;
            tmr <= 32'h0;
          end
        end
        // R11: hold preheat duty for programmed time
        ballast_pkg::ST_PREHEAT: begin
          hw_duty <= ballast_pkg::DUTY_PRE;
          if (ev[ballast_pkg::IRQ_LAMP]) begin
            state <= ballast_pkg::ST_FAULT;
          end else if (tmr >= 32'(PRE_CYC - 1)) begin
            state <= ballast_pkg::ST_IGNITE;
            tmr <= 32'h0;
            ign_step <= 6'h00;
          end
        end
        // R11: ignition sweep toward working duty
        ballast_pkg::ST_IGNITE: begin
          if (to_fault) begin
            state <= ballast_pkg::ST_FAULT;
          end else if (ni) begin
            // R14: count restrike and preheat again
            tries <= tries + 8'h01;
            state <= ballast_pkg::ST_PREHEAT;
            tmr <= 32'h0;
          end else if (tmr >= 32'(IGN_CYC - 1)) begin
            tmr <= 32'h0;
            if (hw_duty < ballast_pkg::DUTY_IGN_END) begin
              hw_duty <= hw_duty + 8'h01;
              ign_step <= ign_step + 6'h01;
            end else begin
              state <= ballast_pkg::ST_RUN;
            end
          end
        end
        ballast_pkg::ST_RUN: begin
          if (to_fault) state <= ballast_pkg::ST_FAULT;
        end
        ballast_pkg::ST_FAULT: begin
          tmr <= 32'h0;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ballast-side outputs, all registered
  // R7: four ballast outputs
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_soft_pwm_output <= 1'b0;
      o_timer_pwm_output <= 1'b0;
    end else if (i_ce) begin
      o_soft_pwm_output <= sw.out;
      o_timer_pwm_output <= hw.out;
    end
  end

  // R15: pfc off at fault; o_pfc_off_output is low from reset on, not only from ignition
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_pfc_off_output <= 1'b0;
      o_driver_shutdown_output <= 1'b0;
    end else if (i_ce) begin
      if (to_fault) begin
        o_pfc_off_output <= 1'b1;
        o_driver_shutdown_output <= 1'b1; // R12: holds controller off
      end else if (state == ballast_pkg::ST_IGNITE) begin
        o_pfc_off_output <= 1'b0;
      end
    end
  end

  // R3: supply cut on open load or exhausted restrikes
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_supply_cut <= 1'b0;
    end else if (i_ce && (cut_req || to_fault)) begin
      o_supply_cut <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // apb slave, one wait-free access phase
  assign acc = i_psel && i_penable;
  assign rd_irq = acc && !i_pwrite && (i_paddr == ballast_pkg::A_IRQ);

  // control and dim registers
  // R10: restrike limit is software set
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      enable <= 1'b1;
      restrike_lim <= ballast_pkg::DEF_RESTRIKES;
      dim <= ballast_pkg::DEF_SW_DUTY;
      irq_mask <= '0;
    end else if (i_ce && acc && i_pwrite && state == ballast_pkg::ST_WAIT_PG
                 && i_paddr == ballast_pkg::A_CTRL) begin
      enable <= i_pwdata[0];
      restrike_lim <= i_pwdata[15:8];
    end else if (i_ce && acc && i_pwrite) begin
      if (i_paddr == ballast_pkg::A_DIM) dim <= i_pwdata[7:0];
      if (i_paddr == ballast_pkg::A_MASK)
        irq_mask <= i_pwdata[ballast_pkg::IRQ_W-1:0];
    end
  end

  // sticky events: a read clears only the bits it reported, set wins
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      irq_st <= '0;
    end else if (i_ce) begin
      irq_st <= (rd_irq ? (irq_st & ~o_prdata[ballast_pkg::IRQ_W-1:0])
                        : irq_st) | ev;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= |(irq_st & irq_mask);
    end
  end

  // read mux and ready
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      o_prdata <= 32'h0;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else if (i_ce) begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0;
      if (i_psel && !i_penable) begin
        unique case (i_paddr)
          ballast_pkg::A_CTRL: o_prdata <= {16'h0, restrike_lim, 7'h0, enable};
          ballast_pkg::A_DIM: o_prdata <= {24'h0, dim};
          ballast_pkg::A_STATUS:
            o_prdata <= {16'h0, tries, 1'b0, ni, lm, pg, 1'b0, 3'(state)};
          ballast_pkg::A_IRQ: o_prdata <= {29'h0, irq_st};
          ballast_pkg::A_MASK: o_prdata <= {29'h0, irq_mask};
          ballast_pkg::A_STATE: o_prdata <= {18'h0, ign_step, hw_duty};
          default: o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // assertions
  property p_wait_quiet;
    @(posedge i_mclk) disable iff (i_srst)
    (state == ballast_pkg::ST_WAIT_PG) |-> !o_driver_shutdown_output;
  endproperty
  a_wait_quiet: assert property (p_wait_quiet) // R1
    else $error("shutdown before power good");
  property p_cut;
    @(posedge i_mclk) disable iff (i_srst)
    (i_ce && cut_req) |=> o_supply_cut;
  endproperty
  a_cut: assert property (p_cut) // R3
    else $error("supply cut missing");
  property p_order;
    @(posedge i_mclk) disable iff (i_srst)
    (state == ballast_pkg::ST_RUN) |-> $past(state) inside
      {ballast_pkg::ST_RUN, ballast_pkg::ST_IGNITE};
  endproperty
  a_order: assert property (p_order) // R4
    else $error("run entered out of order");
  property p_fault_out;
    @(posedge i_mclk) disable iff (i_srst)
    (i_ce && to_fault) |=> o_pfc_off_output && o_driver_shutdown_output;
  endproperty
  a_fault_out: assert property (p_fault_out) // R15
    else $error("fault outputs not set");
  property p_restrike;
    @(posedge i_mclk) disable iff (i_srst)
    (i_ce && state == ballast_pkg::ST_IGNITE && ni && tries < restrike_lim)
      |=> state == ballast_pkg::ST_PREHEAT;
  endproperty
  a_restrike: assert property (p_restrike) // R14
    else $error("restrike not taken");
  property p_irq;
    @(posedge i_mclk) disable iff (i_srst)
    (i_ce && ev[ballast_pkg::IRQ_LAMP]) |=> irq_st[ballast_pkg::IRQ_LAMP];
  endproperty
  a_irq: assert property (p_irq) // R8
    else $error("lamp event lost");
  property p_pre_duty;
    @(posedge i_mclk) disable iff (i_srst)
    (state == ballast_pkg::ST_PREHEAT) ##1 (state == ballast_pkg::ST_PREHEAT)
      |-> hw_duty == ballast_pkg::DUTY_PRE;
  endproperty
  a_pre_duty: assert property (p_pre_duty) // R11
    else $error("preheat duty wrong");
  property p_ign_pfc;
    @(posedge i_mclk) disable iff (i_srst)
    (i_ce && state == ballast_pkg::ST_IGNITE && !to_fault)
      |=> !o_pfc_off_output;
  endproperty
  a_ign_pfc: assert property (p_ign_pfc) // R15
    else $error("pfc off during ignition");
  c_run: cover property (@(posedge i_mclk) state == ballast_pkg::ST_RUN);
  c_fault: cover property (@(posedge i_mclk) o_supply_cut);
  c_retry: cover property (@(posedge i_mclk) tries != 8'h00);
endmodule : ballast_supervisor

/* File: test/ballast_partner.sv */
`timescale 1ns/1ns
module ballast_partner #(
  parameter int PG_CYC = 60
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_shutdown,
  input wire logic i_lamp_out,
  input wire logic i_no_strike,
  output logic o_power_good,
  output logic o_lamp_missing,
  output logic o_no_ignition
);
  int cnt;
  logic stopped;
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt <= 0;
      stopped <= 1'b0;
    end else begin
      if (cnt < PG_CYC) cnt <= cnt + 1;
      if (i_shutdown) stopped <= 1'b1;
    end
  end
  assign o_power_good = (cnt >= PG_CYC) && !stopped;
  assign o_lamp_missing = i_lamp_out;
  assign o_no_ignition = i_no_strike && !stopped;
endmodule : ballast_partner

/* File: test/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, e, pg, lm, ni;
  logic spwm, tpwm, pfc, sd, cut, irq;
  logic lamp_out = 1'b0;
  logic no_strike = 1'b0;
  logic ce = 1'b1;
  int failures = 0;
  int checks = 0;
  int h, s;

  // 125 MHz clock
  always #4 mclk = ~mclk;

  ballast_supervisor #(.PRE_CYC(40), .GEN_CYC(10), .IGN_CYC(4),
    .LOAD_CYC(8)) ballast_supervisor_i (
    .i_mclk(mclk), .i_srst(srst), .i_ce(ce),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr),
    .i_power_good_input(pg), .i_lamp_missing_input(lm),
    .i_no_ignition_input(ni), .o_soft_pwm_output(spwm),
    .o_timer_pwm_output(tpwm), .o_pfc_off_output(pfc),
    .o_driver_shutdown_output(sd), .o_supply_cut(cut), .o_irq(irq));

  ballast_partner #(.PG_CYC(60)) ballast_partner_i (
    .i_mclk(mclk), .i_srst(srst), .i_shutdown(sd),
    .i_lamp_out(lamp_out), .i_no_strike(no_strike),
    .o_power_good(pg), .o_lamp_missing(lm), .o_no_ignition(ni));

  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      failures++;
      $display("unexpected at %0t: no pready", $time);
      conclude();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
  endtask : rd

  // poll state field with a bound
  task automatic wait_st(input logic [2:0] st);
    int n;
    for (n = 0; n < 300; n++) begin
      apb(1'b0, ballast_pkg::A_STATUS, 32'h0);
      if (r[2:0] === st) return;
    end
    failures++;
    $display("unexpected at %0t: state not reached", $time);
    conclude();
  endtask : wait_st

  task automatic reset_dut();
    @(posedge mclk);
    srst <= 1'b1;
    repeat (20) @(posedge mclk);
    srst <= 1'b0;
  endtask : reset_dut

  ////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    reset_dut();
    rd(ballast_pkg::A_STATUS, 32'h0, 32'hFFFF_FFFF);
    chk({cut, sd, pfc, irq}, 32'h0);
    rd(ballast_pkg::A_CTRL, 32'h0000_0201, 32'hFFFF_FFFF);
    rd(ballast_pkg::A_DIM, 32'h0000_00BC, 32'h0000_00FF);
    rd(ballast_pkg::A_MASK, 32'h0, 32'h0000_0007);
    apb(1'b0, 8'h18, 32'h0);
    chk(e, 32'h1);
    // lamp loss before power good: no output acts yet, only irq_st records the event
    lamp_out <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({cut, sd, pfc, irq}, 32'h0);
    lamp_out <= 1'b0;
    wr(ballast_pkg::A_CTRL, 32'h0000_0101);
    rd(ballast_pkg::A_CTRL, 32'h0000_0101, 32'hFFFF_FFFF);
    wr(ballast_pkg::A_MASK, 32'h0000_0007);
    no_strike <= 1'b1;
    wait_st(3'd5);
    rd(ballast_pkg::A_STATUS, 32'h0000_0105, 32'h0000_FF07);
    chk({cut, sd, pfc, irq}, 32'hF);
    rd(ballast_pkg::A_IRQ, 32'h7, 32'h7);
    rd(ballast_pkg::A_IRQ, 32'h0, 32'h7);
    // clean start through to run
    no_strike <= 1'b0;
    reset_dut();
    wait_st(3'd2);
    wait_st(3'd3);
    wait_st(3'd4);
    rd(ballast_pkg::A_STATE, 32'h0000_00D3, 32'h0000_00FF);
    chk(pfc, 32'h0);
    wr(ballast_pkg::A_CTRL, 32'h0000_0501);
    rd(ballast_pkg::A_CTRL, 32'h0000_0201, 32'hFFFF_FFFF);
    wr(ballast_pkg::A_DIM, 32'h0000_0080);
    rd(ballast_pkg::A_DIM, 32'h0000_0080, 32'h0000_00FF);
    repeat (1024) @(posedge mclk);
    h = 0;
    s = 0;
    repeat (2048) begin
      @(posedge mclk);
      h += (tpwm === 1'b1);
      s += (spwm === 1'b1);
    end
    chk(h > 1648 && h < 1728, 32'h1);
    chk(s > 984 && s < 1064, 32'h1);
    // masked lamp loss, then unmask
    wr(ballast_pkg::A_MASK, 32'h0);
    // clock enable low: the lamp loss must not be seen yet
    ce <= 1'b0;
    lamp_out <= 1'b1;
    repeat (16) @(posedge mclk);
    chk({cut, sd, pfc, irq}, 32'h0);
    ce <= 1'b1;
    repeat (8) @(posedge mclk);
    chk({cut, sd, pfc, irq}, 32'hE);
    wr(ballast_pkg::A_MASK, 32'h0000_0001);
    repeat (2) @(posedge mclk);
    chk(irq, 32'h1);
    rd(ballast_pkg::A_IRQ, 32'h5, 32'h7);
    rd(ballast_pkg::A_STATUS, 32'h5, 32'h7);
    conclude();
  end
endmodule : tb_top
